/* core/p4am_map.svh */
`ifndef P4AM_MAP_SVH
`define P4AM_MAP_SVH
`define P4AM_ADDR_W 8
`define P4AM_OFS_ANALOG_CFG 8'hAF
`define P4AM_OFS_CONV_MODE 8'hB1
`define P4AM_OFS_DIR 8'hC4
`define P4AM_OFS_DATA 8'hD4
`define P4AM_RST_ANALOG_CFG 5'h00
`define P4AM_RST_CONV_MODE 8'h00
`define P4AM_RST_DIR 5'h00
`define P4AM_RST_DATA 5'h00
`define P4AM_RST_SYNC 5'h00
`define P4AM_RST_RDATA 8'h00
`define P4AM_GCE_BIT 4
`define P4AM_SEL_LSB 0
`define P4AM_SEL_MSB 2
`define P4AM_MODE_MASK 8'hF7
`define P4AM_NUM_CH 6
`endif

/* core/p4am_pkg.sv */
package p4am_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } p4am_req_t;
   typedef struct packed {
      logic [4:0] analog_cfg;
      logic [7:0] conv_mode;
      logic [4:0] dir;
      logic [4:0] data;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [7:0] rdata;
   } p4am_state_t;
endpackage

/* core/p4am_chan_decode.sv */
`timescale 1ns/10ps
`include "p4am_map.svh"
module p4am_chan_decode #(
   parameter int NPINS = 5
) (
   input wire logic enable,
   input wire logic [2:0] sel,
   output logic [NPINS-1:0] pin_sel,
   output logic [5:0] chan_onehot
);
   if (NPINS < 1 || NPINS > `P4AM_NUM_CH) begin : g_bad_npins
      $error("p4am_chan_decode: NPINS out of range");
   end
   genvar i;
   generate
      for (i = 0; i < `P4AM_NUM_CH; i++) begin : g_ch
         // Selector value i picks analog input i
         assign chan_onehot[i] = enable && (sel == 3'(i));
      end
   endgenerate
   assign pin_sel = chan_onehot[NPINS-1:0];
endmodule

/* core/p4am_mux.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "p4am_map.svh"
module p4am_mux #(
   parameter int NPINS = 5
) (
   input wire logic mclk,
   input wire logic srst,
   input wire p4am_pkg::p4am_req_t req,
   output logic [7:0] rdata,
   input wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe,
   output logic [NPINS-1:0] analog_connect,
   output logic [5:0] conv_channel,
   output logic [NPINS-1:0] digital_in_enable
);
   if (NPINS != 5) begin : g_bad_npins
      $error("p4am_mux: only five port pins are supported");
   end
   p4am_pkg::p4am_state_t st, next_st;
   logic [NPINS-1:0] pin_sel;
   logic [NPINS-1:0] analog_use;
   logic [NPINS-1:0] dig_ok;
   logic gce;
   logic [2:0] sel;
   assign gce = st.conv_mode[`P4AM_GCE_BIT];
   assign sel = st.conv_mode[`P4AM_SEL_MSB:`P4AM_SEL_LSB];
   p4am_chan_decode #(.NPINS(NPINS)) u_dec (
      .enable(gce),
      .sel(sel),
      .pin_sel(pin_sel),
      .chan_onehot(conv_channel)
   );
   assign analog_connect = pin_sel;
   assign rdata = st.rdata;
   genvar p;
   generate
      for (p = 0; p < NPINS; p++) begin : g_pin
         // Digital path of one pin, cut off while the pin is in analog use
         assign analog_use[p] = st.analog_cfg[p] | pin_sel[p];
         assign dig_ok[p] = ~analog_use[p];
         assign pin_oe[p] = st.dir[p] & dig_ok[p];
         assign pin_out[p] = st.data[p] & dig_ok[p];
         assign digital_in_enable[p] = dig_ok[p];
         pin_cfg_iso_a: assert property (@(posedge mclk) disable iff (srst)
            st.analog_cfg[p]
            |-> !digital_in_enable[p])
            else $error("pure analog pin keeps digital input");
         pin_cut_a: assert property (@(posedge mclk) disable iff (srst)
            st.analog_cfg[p]
            |-> !pin_oe[p] && !pin_out[p])
            else $error("isolated pin still drives");
         pin_free_a: assert property (@(posedge mclk) disable iff (srst)
            !st.analog_cfg[p] && !analog_connect[p]
            |-> digital_in_enable[p])
            else $error("free pin lost digital path");
         pin_force_a: assert property (@(posedge mclk) disable iff (srst)
            gce && sel == 3'(p)
            |-> analog_connect[p] && !digital_in_enable[p])
            else $error("selected pin not forced analog");
         pin_route_a: assert property (@(posedge mclk) disable iff (srst)
            analog_connect[p]
            |-> gce && sel == 3'(p) && conv_channel[p])
            else $error("pin routed without selection");
         pin_drive_a: assert property (@(posedge mclk) disable iff (srst)
            digital_in_enable[p]
            |-> pin_oe[p] == st.dir[p] && pin_out[p] == st.data[p])
            else $error("digital pin driver wrong");
         pin_input_a: assert property (@(posedge mclk) disable iff (srst)
            !st.dir[p]
            |-> !pin_oe[p])
            else $error("input pin driven");
         pin_drv_off_a: assert property (@(posedge mclk) disable iff (srst)
            st.analog_cfg[p] || analog_connect[p]
            |-> !pin_oe[p])
            else $error("analog pin driver on");
         pin_gce_off_a: assert property (@(posedge mclk) disable iff (srst)
            !gce && !st.analog_cfg[p]
            |-> digital_in_enable[p] && !analog_connect[p])
            else $error("pin not digital with enable low");
      end
   endgenerate
   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;
      // Pin sampling, two stages
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;
      if (req.wr) begin
         case (req.addr)
            `P4AM_OFS_ANALOG_CFG: next_st.analog_cfg = req.wdata[4:0];
            `P4AM_OFS_CONV_MODE: next_st.conv_mode = req.wdata & `P4AM_MODE_MASK;
            `P4AM_OFS_DIR: next_st.dir = req.wdata[4:0];
            `P4AM_OFS_DATA: next_st.data = req.wdata[4:0];
            default: ;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            `P4AM_OFS_ANALOG_CFG: next_st.rdata = {3'h0, st.analog_cfg};
            `P4AM_OFS_CONV_MODE: next_st.rdata = st.conv_mode;
            `P4AM_OFS_DIR: next_st.rdata = {3'h0, st.dir};
            // Digital-off pins read zero
            `P4AM_OFS_DATA: next_st.rdata = {3'h0, st.sync2 & dig_ok};
            default: next_st.rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         st.analog_cfg <= `P4AM_RST_ANALOG_CFG;
         st.conv_mode <= `P4AM_RST_CONV_MODE;
         st.dir <= `P4AM_RST_DIR;
         st.data <= `P4AM_RST_DATA;
         st.sync1 <= `P4AM_RST_SYNC;
         st.sync2 <= `P4AM_RST_SYNC;
         st.rdata <= `P4AM_RST_RDATA;
      end else begin
         st <= next_st;
      end
   end
   one_hot_a: assert property (@(posedge mclk) disable iff (srst)
      $onehot0(analog_connect))
      else $error("more than one pin routed");
   cfg_iso_a: assert property (@(posedge mclk) disable iff (srst)
      st.analog_cfg[0]
      |-> !pin_oe[0] && !digital_in_enable[0])
      else $error("analog pin not isolated");
   cfg_free_a: assert property (@(posedge mclk) disable iff (srst)
      !st.analog_cfg[1] && !analog_connect[1]
      |-> digital_in_enable[1])
      else $error("digital pin blocked");
   gce_off_a: assert property (@(posedge mclk) disable iff (srst)
      !gce
      |-> analog_connect == '0)
      else $error("channel with enable low");
   sel_route_a: assert property (@(posedge mclk) disable iff (srst)
      req.wr && req.addr == `P4AM_OFS_CONV_MODE && req.wdata == 8'h12
      |=> analog_connect == 5'h04)
      else $error("selector route wrong");
   sel_decode_a: assert property (@(posedge mclk) disable iff (srst)
      gce && sel == 3'h5
      |-> conv_channel == 6'h20 && analog_connect == '0)
      else $error("channel five decode wrong");
   force_an_a: assert property (@(posedge mclk) disable iff (srst)
      analog_connect[3]
      |-> !pin_oe[3])
      else $error("selected pin still driven");
   dir_drive_a: assert property (@(posedge mclk) disable iff (srst)
      st.dir[2] && !st.analog_cfg[2] && !analog_connect[2]
      |-> pin_oe[2] && pin_out[2] == st.data[2])
      else $error("output not driven");
   drv_off_a: assert property (@(posedge mclk) disable iff (srst)
      (st.analog_cfg | analog_connect) != '0
      |-> (pin_oe & (st.analog_cfg | analog_connect)) == '0)
      else $error("driver on in analog use");
   chan_one_hot_a: assert property (@(posedge mclk) disable iff (srst)
      $onehot0(conv_channel))
      else $error("more than one channel selected");
   conn_match_a: assert property (@(posedge mclk) disable iff (srst)
      analog_connect == conv_channel[NPINS-1:0])
      else $error("pin route differs from channel");
   gce_chan_off_a: assert property (@(posedge mclk) disable iff (srst)
      !gce
      |-> conv_channel == 6'h00)
      else $error("channel active with enable low");
   sel_valid_a: assert property (@(posedge mclk) disable iff (srst)
      gce && sel <= 3'h5
      |-> $onehot(conv_channel))
      else $error("valid selector gave no channel");
   sel_none_a: assert property (@(posedge mclk) disable iff (srst)
      gce && sel > 3'h5
      |-> conv_channel == 6'h00)
      else $error("unused selector gave a channel");
   sel_zero_a: assert property (@(posedge mclk) disable iff (srst)
      gce && sel == 3'h0
      |-> conv_channel == 6'h01 && analog_connect == 5'h01)
      else $error("channel zero decode wrong");
   sel_four_a: assert property (@(posedge mclk) disable iff (srst)
      gce && sel == 3'h4
      |-> conv_channel == 6'h10 && analog_connect == 5'h10)
      else $error("channel four decode wrong");
   mode_off_a: assert property (@(posedge mclk) disable iff (srst)
      req.wr && req.addr == `P4AM_OFS_CONV_MODE && !req.wdata[`P4AM_GCE_BIT]
      |=> analog_connect == 5'h00 && conv_channel == 6'h00)
      else $error("enable clear left a route");
   cfg_wr_a: assert property (@(posedge mclk) disable iff (srst)
      req.wr && req.addr == `P4AM_OFS_ANALOG_CFG
      |=> ({3'h0, digital_in_enable} & $past(req.wdata)) == 8'h00)
      else $error("configured pin kept digital path");
   rd_gate_a: assert property (@(posedge mclk) disable iff (srst)
      $past(req.rd) && $past(req.addr) == `P4AM_OFS_DATA
      |-> ({3'h0, $past(st.analog_cfg)} & rdata) == 8'h00)
      else $error("isolated pin seen on read");
   rd_cfg_a: assert property (@(posedge mclk) disable iff (srst)
      $past(req.rd) && $past(req.addr) == `P4AM_OFS_ANALOG_CFG
      |-> rdata == {3'h0, $past(st.analog_cfg)})
      else $error("configuration read wrong");
   wr_dir_a: assert property (@(posedge mclk) disable iff (srst)
      req.wr && req.addr == `P4AM_OFS_DIR
      |=> {3'h0, pin_oe} == ($past(req.wdata) & {3'h0, dig_ok}))
      else $error("direction write not applied");
   wr_data_a: assert property (@(posedge mclk) disable iff (srst)
      req.wr && req.addr == `P4AM_OFS_DATA
      |=> {3'h0, pin_out} == ($past(req.wdata) & {3'h0, dig_ok}))
      else $error("output latch write not applied");
   mode_rd_a: assert property (@(posedge mclk) disable iff (srst)
      $past(req.rd) && $past(req.addr) == `P4AM_OFS_CONV_MODE
      |-> rdata == $past(st.conv_mode))
      else $error("mode read wrong");
endmodule

/* testbench/p4am_pins.sv */
`timescale 1ns/10ps
module p4am_pins (
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [4:0] ext_level,
   output logic [4:0] pin_in
);
   // Driven pins show the driven level, the others the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin \
   checks++; \
   if ((s) !== (e)) begin \
      n_fail++; \
      $display("BAD %s %h %h", n, e, s); \
   end \
end
module testbench;
   logic mclk = 0;
   logic srst = 1;
   p4am_pkg::p4am_req_t req = '0;
   logic [7:0] rdata;
   logic [4:0] pin_in, pin_out, pin_oe, ac, din;
   logic [4:0] ext = 5'h15;
   logic [5:0] ch;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   initial forever #25 mclk = ~mclk;
   p4am_mux p4am_mux_inst (.mclk(mclk), .srst(srst), .req(req), .rdata(rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .analog_connect(ac),
      .conv_channel(ch), .digital_in_enable(din));
   p4am_pins p4am_pins_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_in(pin_in));
   task automatic give_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk) req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk) req.rd <= 1'b0;
      #1 `CHK("rdata", e, rdata)
   endtask
   task automatic t_reset();
      rd_chk(8'hAF, 8'h00);
      rd_chk(8'hB1, 8'h00);
      `CHK("rst", 11'h000, {ac, ch})
      $display("t_reset done");
   endtask
   task automatic t_sel();
      wr(8'hD4, 8'h1F);
      wr(8'hC4, 8'h1F);
      for (int i = 0; i < 7; i++) begin
         wr(8'hB1, 8'h10 | 8'(i));
         `CHK("chan", (i < 6) ? 6'(1 << i) : 6'h00, ch)
         `CHK("conn", (i < 5) ? 5'(1 << i) : 5'h00, ac)
         `CHK("oe", (i < 5) ? ~5'(1 << i) : 5'h1F, pin_oe)
         `CHK("out", (i < 5) ? ~5'(1 << i) : 5'h1F, pin_out)
      end
      wr(8'hB1, 8'h02);
      `CHK("off", 16'h001F, {ac, ch, pin_oe})
      repeat (2) @(posedge mclk);
      rd_chk(8'hD4, 8'h1F);
      $display("t_sel done");
   endtask
   task automatic t_cfg();
      wr(8'hAF, 8'h05);
      `CHK("cfg oe", 5'h1A, pin_oe)
      `CHK("din", 5'h1A, din)
      `CHK("cfg out", 5'h1A, pin_out)
      wr(8'hC4, 8'h00);
      repeat (2) @(posedge mclk);
      rd_chk(8'hD4, 8'h10);
      rd_chk(8'h10, 8'h00);
      wr(8'hAF, 8'hFF);
      rd_chk(8'hAF, 8'h1F);
      wr(8'hB1, 8'hFF);
      rd_chk(8'hB1, 8'hF7);
      @(posedge mclk) srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      rd_chk(8'hAF, 8'h00);
      `CHK("rst2", 16'hF800, {din, ch, pin_oe})
      $display("t_cfg done");
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_sel();
      t_cfg();
      give_verdict();
   end
endmodule
